/* core/nms_conviction.sv */
// Purpose: turns per-observer accusations into collective convictions
// Assumes: accusation matrix is valid with its strobe, one row per observer
// Notes:   threshold is a parameter; a lone accusation never convicts while THRESHOLD is 2 or more
module nms_conviction #(
	parameter int unsigned NODES     = 4,
	parameter int unsigned THRESHOLD = 2
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic                   clear,
	input  wire logic                   acc_valid,
	input  wire logic [NODES*NODES-1:0] acc_matrix,
	output logic      [NODES-1:0]       convicted_q
);
	logic [NODES-1:0] verdict_d;

	// count observers accusing each defendant
	always_comb
	begin
		int unsigned cnt;
		cnt = 0;
		verdict_d = '0;
		for (int d = 0; d < NODES; d++)
		begin
			cnt = 0;
			for (int o = 0; o < NODES; o++)
				if (acc_matrix[o*NODES+d])
					cnt++;
			verdict_d[d] = (cnt >= THRESHOLD);
		end
	end

	// convictions are sticky until clear (driven in self-test by the sequencer)
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			convicted_q <= '0;
		else if (ce)
		begin
			if (acc_valid)
				convicted_q <= (clear ? '0 : convicted_q) | verdict_d;
			else if (clear)
				convicted_q <= '0;
		end
	end
endmodule // nms_conviction

/* core/nms_pkg.sv */
// Purpose: shared constants and types for the node mode sequencer
// Assumes: one clock at 25 MHz, protocol engine supplies phase-done strobes
// Notes:   vote width and lane count are package defaults, overridable per module
package nms_pkg;
	typedef enum logic [3:0] {
		NMS_SELF_TEST,
		NMS_DET_LOCAL_DIAG,
		NMS_DET_SYNC_ACQ,
		NMS_DET_COLL_DIAG,
		NMS_JOIN,
		NMS_INIT_DIAG,
		NMS_INIT_SYNC,
		NMS_INIT_COLL_DIAG,
		NMS_PRES_SCHED_UPD,
		NMS_PRES_CLIENT_BCAST,
		NMS_PRES_ACCUSE_XCHG,
		NMS_PRES_SYNC,
		NMS_PRES_COLL_DIAG
	} nms_mode_e;

	// major mode codes shown on major_mode
	localparam logic [2:0] MAJ_SELF_TEST = 3'h0;
	localparam logic [2:0] MAJ_DETECT    = 3'h1;
	localparam logic [2:0] MAJ_JOIN      = 3'h2;
	localparam logic [2:0] MAJ_INIT      = 3'h3;
	localparam logic [2:0] MAJ_PRESERVE  = 3'h4;

	// diagnostic cycles a joining node must complete
	localparam int unsigned JOIN_DIAG_CYCLES = 2;
	// self-test holds outputs off and reset asserted this many cycles first
	localparam int unsigned ST_RESET_CYCLES  = 4;
	localparam int unsigned DATA_W           = 8;
	localparam int unsigned LANES            = 4;
endpackage : nms_pkg

/* core/nms_sequencer.sv */
// Purpose: major/minor operational mode sequencing and fail-stop policy for one bus node
// Assumes: protocol engine raises one-cycle done strobes per minor mode; ce gates all state
// Notes:   error inputs are same-domain logic; only pwr_on_en is asynchronous and synchronised
module nms_sequencer #(
	parameter int unsigned W          = nms_pkg::DATA_W,
	parameter int unsigned LANES      = nms_pkg::LANES,
	parameter int unsigned CONV_THRESH = 2,
	parameter bit          IS_ACCESS  = 1'b1
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic                     pwr_on_en,
	input  wire logic                     self_test_pass,
	input  wire logic                     self_test_fail,
	input  wire logic                     self_check_err,
	input  wire logic                     bus_fail,
	input  wire logic                     clique_found,
	input  wire logic                     clique_absent,
	input  wire logic                     phase_done,
	input  wire logic                     diag_cycle_done,
	input  wire logic                     admitted,
	input  wire logic                     sched_valid,
	input  wire logic                     rx_valid,
	input  wire logic                     rx_in_window,
	input  wire logic                     rx_format_ok,
	input  wire logic [LANES*W-1:0]       rx_lanes,
	input  wire logic [LANES-1:0]         eligible,
	input  wire logic                     client_valid,
	input  wire logic                     client_format_ok,
	input  wire logic                     client_bcast_done,
	input  wire logic                     acc_valid,
	input  wire logic [LANES*LANES-1:0]   acc_matrix,
	output logic                          link_tx_en_q,
	output logic                          circuit_rst_q,
	output logic                          self_test_run_q,
	output logic      [2:0]               major_mode_q,
	output logic      [3:0]               minor_mode_q,
	output logic                          member_q,
	output logic                          service_en_q,
	output logic                          sched_dl_q,
	output logic                          accuse_xchg_q,
	output logic                          inline_err_q,
	output logic      [LANES-1:0]         xlane_err_q,
	output logic                          client_err_q,
	output logic                          fail_q,
	output logic                          voted_valid_q,
	output logic      [W-1:0]             voted_data_q,
	output logic      [LANES-1:0]         convicted_q
);
	nms_pkg::nms_mode_e mode_q;
	nms_pkg::nms_mode_e mode_d;
	logic               pon_s1_q;
	logic               pon_s2_q;
	logic               pon_seen_q;
	logic [2:0]         st_cnt_q;
	logic [1:0]         join_cnt_q;
	logic               fault;
	logic               st_ready;
	logic               enter_st;

	// power-on enable comes from outside and is synchronised first
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pon_s1_q <= 1'b0;
			pon_s2_q <= 1'b0;
		end
		else if (ce)
		begin
			pon_s1_q <= pwr_on_en;
			pon_s2_q <= pon_s1_q;
		end
	end

	// local failure is a self-check error, bus failure comes from bus assessment
	assign fault    = self_check_err | bus_fail;
	assign st_ready = (st_cnt_q == 3'(nms_pkg::ST_RESET_CYCLES));
	assign enter_st = (mode_q != nms_pkg::NMS_SELF_TEST) && fault;

	// remembers a rising power-on enable so self-test restarts from scratch
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pon_seen_q <= 1'b0;
		else if (ce)
			pon_seen_q <= pon_s2_q;
	end

	// next mode: failures win over every other transition
	always_comb
	begin
		mode_d = mode_q;
		if (fault || (pon_s2_q && !pon_seen_q))
			mode_d = nms_pkg::NMS_SELF_TEST;
		else
			unique case (mode_q)
				nms_pkg::NMS_SELF_TEST:
					if (st_ready && pon_s2_q && self_test_pass && !self_test_fail)
						mode_d = nms_pkg::NMS_DET_LOCAL_DIAG;
				nms_pkg::NMS_DET_LOCAL_DIAG:
					if (clique_absent)
						mode_d = nms_pkg::NMS_INIT_DIAG;
					else if (phase_done)
						mode_d = nms_pkg::NMS_DET_SYNC_ACQ;
				nms_pkg::NMS_DET_SYNC_ACQ:
					if (clique_absent)
						mode_d = nms_pkg::NMS_INIT_DIAG;
					else if (phase_done)
						mode_d = nms_pkg::NMS_DET_COLL_DIAG;
				nms_pkg::NMS_DET_COLL_DIAG:
					if (clique_absent)
						mode_d = nms_pkg::NMS_INIT_DIAG;
					else if (clique_found)
						mode_d = nms_pkg::NMS_JOIN;
				nms_pkg::NMS_JOIN:
					if (admitted && join_cnt_q == 2'(nms_pkg::JOIN_DIAG_CYCLES))
						mode_d = nms_pkg::NMS_PRES_SCHED_UPD;
				nms_pkg::NMS_INIT_DIAG:
					if (phase_done)
						mode_d = nms_pkg::NMS_INIT_SYNC;
				nms_pkg::NMS_INIT_SYNC:
					if (phase_done)
						mode_d = nms_pkg::NMS_INIT_COLL_DIAG;
				nms_pkg::NMS_INIT_COLL_DIAG:
					if (phase_done)
						mode_d = nms_pkg::NMS_PRES_SCHED_UPD;
				nms_pkg::NMS_PRES_SCHED_UPD:
					if (phase_done && sched_valid)
						mode_d = nms_pkg::NMS_PRES_CLIENT_BCAST;
				nms_pkg::NMS_PRES_CLIENT_BCAST:
					if (client_bcast_done)
						mode_d = nms_pkg::NMS_PRES_ACCUSE_XCHG;
				nms_pkg::NMS_PRES_ACCUSE_XCHG:
					if (phase_done)
						mode_d = nms_pkg::NMS_PRES_SYNC;
				nms_pkg::NMS_PRES_SYNC:
					if (phase_done)
						mode_d = nms_pkg::NMS_PRES_COLL_DIAG;
				nms_pkg::NMS_PRES_COLL_DIAG:
					if (phase_done)
						mode_d = nms_pkg::NMS_PRES_SCHED_UPD;
				default:
					mode_d = nms_pkg::NMS_SELF_TEST;
			endcase
	end

	// mode register, reset lands in self-test
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			mode_q <= nms_pkg::NMS_SELF_TEST;
		else if (ce)
			mode_q <= mode_d;
	end

	// self-test entry holds circuitry in reset a few cycles before testing
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_cnt_q <= '0;
		else if (ce)
		begin
			if (mode_d != nms_pkg::NMS_SELF_TEST || enter_st || (pon_s2_q && !pon_seen_q))
				st_cnt_q <= '0;
			else if (!st_ready)
				st_cnt_q <= st_cnt_q + 3'h1;
		end
	end

	// join diagnostic cycle counter, saturating at the required count
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			join_cnt_q <= '0;
		else if (ce)
		begin
			if (mode_q != nms_pkg::NMS_JOIN)
				join_cnt_q <= '0;
			else if (diag_cycle_done && join_cnt_q != 2'(nms_pkg::JOIN_DIAG_CYCLES))
				join_cnt_q <= join_cnt_q + 2'h1;
		end
	end

	// fail-stop link enable and self-test controls
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			link_tx_en_q    <= 1'b0;
			circuit_rst_q   <= 1'b1;
			self_test_run_q <= 1'b0;
			fail_q          <= 1'b0;
		end
		else if (ce)
		begin
			link_tx_en_q    <= !fault && mode_d != nms_pkg::NMS_SELF_TEST;
			circuit_rst_q   <= mode_d == nms_pkg::NMS_SELF_TEST && (!st_ready || enter_st);
			self_test_run_q <= mode_d == nms_pkg::NMS_SELF_TEST && st_ready && !enter_st;
			fail_q          <= fault;
		end
	end

	// major and minor mode view plus membership
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			major_mode_q  <= nms_pkg::MAJ_SELF_TEST;
			minor_mode_q  <= '0;
			member_q      <= 1'b0;
			service_en_q  <= 1'b0;
			sched_dl_q    <= 1'b0;
			accuse_xchg_q <= 1'b0;
		end
		else if (ce)
		begin
			minor_mode_q  <= mode_d;
			unique case (mode_d)
				nms_pkg::NMS_SELF_TEST:
					major_mode_q <= nms_pkg::MAJ_SELF_TEST;
				nms_pkg::NMS_DET_LOCAL_DIAG, nms_pkg::NMS_DET_SYNC_ACQ, nms_pkg::NMS_DET_COLL_DIAG:
					major_mode_q <= nms_pkg::MAJ_DETECT;
				nms_pkg::NMS_JOIN:
					major_mode_q <= nms_pkg::MAJ_JOIN;
				nms_pkg::NMS_INIT_DIAG, nms_pkg::NMS_INIT_SYNC, nms_pkg::NMS_INIT_COLL_DIAG:
					major_mode_q <= nms_pkg::MAJ_INIT;
				default:
					major_mode_q <= nms_pkg::MAJ_PRESERVE;
			endcase
			member_q      <= mode_d >= nms_pkg::NMS_PRES_SCHED_UPD;
			service_en_q  <= mode_d >= nms_pkg::NMS_PRES_SCHED_UPD;
			sched_dl_q    <= mode_d == nms_pkg::NMS_PRES_SCHED_UPD;
			accuse_xchg_q <= mode_d == nms_pkg::NMS_PRES_ACCUSE_XCHG;
		end
	end

	// in-line and client checks on each received message
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			inline_err_q <= 1'b0;
			client_err_q <= 1'b0;
		end
		else if (ce)
		begin
			inline_err_q <= rx_valid && !(rx_in_window && rx_format_ok);
			client_err_q <= IS_ACCESS && client_valid && !client_format_ok;
		end
	end

	// dynamic vote over eligible lanes gives cross-lane errors
	nms_vote #(
		.W     (W),
		.LANES (LANES)
	) u_vote (
		.clk         (clk),
		.rst         (rst),
		.ce          (ce),
		.in_valid    (rx_valid),
		.in_data     (rx_lanes),
		.eligible    (eligible),
		.out_valid_q (voted_valid_q),
		.out_data_q  (voted_data_q),
		.mismatch_q  (xlane_err_q)
	);

	// accusations become convictions only on observer agreement
	nms_conviction #(
		.NODES     (LANES),
		.THRESHOLD (CONV_THRESH)
	) u_conv (
		.clk         (clk),
		.rst         (rst),
		.ce          (ce),
		.clear       (mode_q == nms_pkg::NMS_SELF_TEST),
		.acc_valid   (acc_valid && mode_q == nms_pkg::NMS_PRES_COLL_DIAG),
		.acc_matrix  (acc_matrix),
		.convicted_q (convicted_q)
	);
endmodule // nms_sequencer

/* core/nms_vote.sv */
// Purpose: dynamic majority vote over eligible lanes with cross-lane mismatch flags
// Assumes: lanes arrive together with one valid strobe
// Notes:   an ineligible lane never counts toward the vote nor gets accused
module nms_vote #(
	parameter int unsigned W     = 8,
	parameter int unsigned LANES = 4
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	input  wire logic                 in_valid,
	input  wire logic [LANES*W-1:0]   in_data,
	input  wire logic [LANES-1:0]     eligible,
	output logic                      out_valid_q,
	output logic      [W-1:0]         out_data_q,
	output logic      [LANES-1:0]     mismatch_q
);
	logic [W-1:0]     voted_d;
	logic [LANES-1:0] mism_d;

	// bitwise majority among eligible lanes, ties resolve to zero
	always_comb
	begin
		int unsigned ones;
		int unsigned n;
		ones = 0;
		n = 0;
		voted_d = '0;
		mism_d = '0;
		for (int l = 0; l < LANES; l++)
			if (eligible[l])
				n++;
		for (int b = 0; b < W; b++)
		begin
			ones = 0;
			for (int l = 0; l < LANES; l++)
				if (eligible[l] && in_data[l*W+b])
					ones++;
			voted_d[b] = (2*ones > n);
		end
		for (int l = 0; l < LANES; l++)
			mism_d[l] = eligible[l] && (in_data[l*W +: W] != voted_d);
	end

	// register vote result and per-lane cross-lane errors
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
			mismatch_q  <= '0;
		end
		else if (ce)
		begin
			out_valid_q <= in_valid;
			if (in_valid)
			begin
				out_data_q <= voted_d;
				mismatch_q <= mism_d;
			end
			else
				mismatch_q <= '0;
		end
	end
endmodule // nms_vote

/* test/nms_peer_model.sv */
// Purpose: peer clique model answering each minor mode of the sequencer
// Assumes: replies come dly cycles after a mode is entered, one cycle strobes except the admitted and sched_valid levels
// Notes:   park holds preservation diagnosis open; want_clique picks the verdict
module nms_peer_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] minor_mode_q,
	input  wire logic [7:0] dly,
	input  wire logic       want_clique,
	input  wire logic       park,
	output logic            phase_done,
	output logic            clique_found,
	output logic            clique_absent,
	output logic            diag_cycle_done,
	output logic            admitted,
	output logic            sched_valid,
	output logic            client_bcast_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_q;
	logic [3:0] last_q;
	logic [1:0] ndiag_q;
	logic       hit;
	// reply is due once the node has sat dly cycles in one mode
	assign hit = (cnt_q == dly) && (minor_mode_q == last_q);
	// reply timer, restarted on each mode change and each join cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 8'h00;
			last_q <= 4'h0;
			ndiag_q <= 2'h0;
		end
		else
		begin
			last_q <= minor_mode_q;
			cnt_q <= (minor_mode_q != last_q || (hit && minor_mode_q == 4'h4)) ? 8'h00 : cnt_q + 8'h01;
			ndiag_q <= (minor_mode_q != 4'h4) ? 2'h0 : ndiag_q + {1'b0, hit && ndiag_q != 2'h2};
		end
	end
	// strobes and levels seen by the node
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			phase_done <= 1'b0;
			clique_found <= 1'b0;
			clique_absent <= 1'b0;
			diag_cycle_done <= 1'b0;
			admitted <= 1'b0;
			sched_valid <= 1'b0;
			client_bcast_done <= 1'b0;
		end
		else
		begin
			phase_done <= hit && ((minor_mode_q inside {4'h1, 4'h2, 4'h3} && want_clique)
				|| minor_mode_q inside {4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hb} || (minor_mode_q == 4'hc && !park));
			clique_found <= hit && minor_mode_q == 4'h3 && want_clique;
			clique_absent <= hit && minor_mode_q == 4'h1 && !want_clique;
			diag_cycle_done <= hit && minor_mode_q == 4'h4;
			admitted <= ndiag_q == 2'h2;
			sched_valid <= minor_mode_q == 4'h8;
			client_bcast_done <= hit && minor_mode_q == 4'h9;
		end
	end
endmodule // nms_peer_model

/* test/nms_sequencer_asserts.sv */
// Purpose: concurrent checks on the node mode sequencer ports
// Assumes: one clock domain, reset asynchronous and active high
// Notes:   join_cnt_q mirrors the diagnostic cycles seen while joining
module nms_sequencer_asserts (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       ce,
	input wire logic       self_test_pass,
	input wire logic       self_test_fail,
	input wire logic       self_check_err,
	input wire logic       bus_fail,
	input wire logic       clique_absent,
	input wire logic       diag_cycle_done,
	input wire logic       rx_valid,
	input wire logic       rx_in_window,
	input wire logic       rx_format_ok,
	input wire logic       client_valid,
	input wire logic       client_format_ok,
	input wire logic       link_tx_en_q,
	input wire logic       circuit_rst_q,
	input wire logic       self_test_run_q,
	input wire logic [2:0] major_mode_q,
	input wire logic [3:0] minor_mode_q,
	input wire logic       member_q,
	input wire logic       service_en_q,
	input wire logic       inline_err_q,
	input wire logic       client_err_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [1:0] join_cnt_q;
	logic [3:0] pres_next;
	// counts diagnostic cycle strobes while joining
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			join_cnt_q <= 2'h0;
		else if (ce)
			join_cnt_q <= (major_mode_q != 3'h2) ? 2'h0 : join_cnt_q + {1'b0, diag_cycle_done && join_cnt_q != 2'h3};
	end
	// successor of each preservation minor mode
	assign pres_next = (minor_mode_q == 4'hc) ? 4'h8 : minor_mode_q + 4'h1;
	sequence s_leave_st;
		major_mode_q == 3'h0 ##1 major_mode_q != 3'h0;
	endsequence
	sequence s_join_done;
		major_mode_q == 3'h2 ##1 major_mode_q == 3'h4;
	endsequence
	sequence s_enter_st;
		major_mode_q != 3'h0 ##1 major_mode_q == 3'h0;
	endsequence
	// minor mode moved while the major mode held
	sequence s_same_major_step;
		major_mode_q == $past(major_mode_q) && minor_mode_q != $past(minor_mode_q);
	endsequence
	a_fault_stop:
		assert property (ce && (self_check_err || bus_fail) |=> major_mode_q == 3'h0 && !link_tx_en_q)
		else $error("fault did not stop node");
	a_st_exit_pass:
		assert property (s_leave_st |-> $past(self_test_pass) && !$past(self_test_fail) && minor_mode_q == 4'h1)
		else $error("bad self-test exit");
	a_st_entry_off:
		assert property (s_enter_st |-> circuit_rst_q && !link_tx_en_q && !self_test_run_q)
		else $error("self-test entry left outputs on");
	a_service_member:
		assert property (service_en_q |-> member_q && major_mode_q == 3'h4)
		else $error("service without membership");
	a_join_two_cycles:
		assert property (s_join_done |-> $past(join_cnt_q) >= 2'h2)
		else $error("join left early");
	a_minor_step:
		assert property (major_mode_q inside {3'h1, 3'h3} ##1 s_same_major_step |-> minor_mode_q == $past(minor_mode_q) + 4'h1)
		else $error("minor mode skipped");
	a_pres_loop:
		assert property (major_mode_q == 3'h4 ##1 s_same_major_step |-> minor_mode_q == $past(pres_next))
		else $error("preservation order broken");
	a_det_absent:
		assert property (major_mode_q == 3'h1 ##1 major_mode_q == 3'h3 |-> minor_mode_q == 4'h5 && $past(clique_absent))
		else $error("bad move to initialisation");
	a_inline_err:
		assert property (ce && rx_valid |=> inline_err_q == $past(!(rx_in_window && rx_format_ok)))
		else $error("in-line check wrong");
	a_client_err:
		assert property (ce && client_valid |=> client_err_q == $past(!client_format_ok))
		else $error("client check wrong");
endmodule // nms_sequencer_asserts

bind nms_sequencer nms_sequencer_asserts nms_sequencer_asserts_inst (.clk, .rst, .ce, .self_test_pass, .self_test_fail,
	.self_check_err, .bus_fail, .clique_absent, .diag_cycle_done, .rx_valid, .rx_in_window, .rx_format_ok, .client_valid,
	.client_format_ok, .link_tx_en_q, .circuit_rst_q, .self_test_run_q, .major_mode_q, .minor_mode_q, .member_q,
	.service_en_q, .inline_err_q, .client_err_q);

/* test/tb.sv */
// Purpose: self-checking bench for the node mode sequencer
// Assumes: peer model answers each minor mode after dly cycles
// Notes:   one task per scenario, each judging its own results
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst, ce, pwr_on_en, self_test_pass, self_test_fail, self_check_err, bus_fail;
	logic        clique_found, clique_absent, phase_done, diag_cycle_done, admitted, sched_valid, client_bcast_done;
	logic        rx_valid, rx_in_window, rx_format_ok, client_valid, client_format_ok, acc_valid, want_clique, park;
	logic [31:0] rx_lanes;
	logic [15:0] acc_matrix;
	logic [7:0]  dly, voted_data_q;
	logic [3:0]  eligible, minor_mode_q, xlane_err_q, convicted_q;
	logic [2:0]  major_mode_q;
	logic        link_tx_en_q, circuit_rst_q, self_test_run_q, member_q, service_en_q, sched_dl_q;
	logic        accuse_xchg_q, inline_err_q, client_err_q, fail_q, voted_valid_q;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cyc = 0;
	nms_sequencer nms_sequencer_inst (.clk, .rst, .ce, .pwr_on_en, .self_test_pass, .self_test_fail, .self_check_err,
		.bus_fail, .clique_found, .clique_absent, .phase_done, .diag_cycle_done, .admitted, .sched_valid, .rx_valid,
		.rx_in_window, .rx_format_ok, .rx_lanes, .eligible, .client_valid, .client_format_ok, .client_bcast_done,
		.acc_valid, .acc_matrix, .link_tx_en_q, .circuit_rst_q, .self_test_run_q, .major_mode_q, .minor_mode_q,
		.member_q, .service_en_q, .sched_dl_q, .accuse_xchg_q, .inline_err_q, .xlane_err_q, .client_err_q, .fail_q,
		.voted_valid_q, .voted_data_q, .convicted_q);
	nms_peer_model nms_peer_model_inst (.clk, .rst, .minor_mode_q, .dly, .want_clique, .park, .phase_done,
		.clique_found, .clique_absent, .diag_cycle_done, .admitted, .sched_valid, .client_bcast_done);
	// 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask
	task automatic wait_mode(logic [2:0] maj, logic [3:0] mn);
		for (int i = 0; i < 200 && minor_mode_q !== mn; i++)
			@(posedge clk) #1;
		chk("major_mode_q", maj, major_mode_q);
		chk("minor_mode_q", mn, minor_mode_q);
	endtask
	task automatic t_self_test;
		chk("minor_mode_q", 4'h0, minor_mode_q);
		chk("circuit_rst_q", 1'b1, circuit_rst_q);
		@(posedge clk);
		pwr_on_en <= 1'b1;
		{self_test_pass, self_test_fail} <= 2'h3;
		repeat (60) @(posedge clk);
		self_test_fail <= 1'b0;
		#1 chk("major_mode_q", 3'h0, major_mode_q);
		chk("self_test_run_q", 1'b1, self_test_run_q);
		wait_mode(3'h1, 4'h1);
		chk("link_tx_en_q", 1'b1, link_tx_en_q);
	endtask
	task automatic t_join_pres;
		wait_mode(3'h1, 4'h2);
		wait_mode(3'h1, 4'h3);
		wait_mode(3'h2, 4'h4);
		chk("service_en_q", 1'b0, service_en_q);
		wait_mode(3'h4, 4'h8);
		chk("sched_dl_q", 1'b1, sched_dl_q);
		chk("service_en_q", 1'b1, service_en_q);
		chk("member_q", 1'b1, member_q);
		wait_mode(3'h4, 4'h9);
		wait_mode(3'h4, 4'ha);
		chk("accuse_xchg_q", 1'b1, accuse_xchg_q);
		wait_mode(3'h4, 4'hb);
		wait_mode(3'h4, 4'hc);
		wait_mode(3'h4, 4'h8);
	endtask
	task automatic t_vote;
		@(posedge clk);
		rx_lanes <= {8'h5a, 8'h33, 8'h5a, 8'h5a};
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_valid <= 1'b0;
		#1 chk("voted_data_q", 8'h5a, voted_data_q);
		chk("voted_valid_q", 1'b1, voted_valid_q);
		chk("xlane_err_q", 4'h4, xlane_err_q);
		chk("inline_err_q", 1'b0, inline_err_q);
		@(posedge clk);
		{rx_valid, rx_in_window, eligible, client_valid, client_format_ok} <= {1'b1, 1'b0, 4'hb, 1'b1, 1'b0};
		@(posedge clk);
		{rx_valid, rx_in_window, eligible, client_valid, client_format_ok} <= {1'b0, 1'b1, 4'hf, 1'b0, 1'b1};
		#1 chk("inline_err_q", 1'b1, inline_err_q);
		chk("xlane_err_q", 4'h0, xlane_err_q);
		chk("client_err_q", 1'b1, client_err_q);
	endtask
	task automatic t_convict;
		park <= 1'b1;
		wait_mode(3'h4, 4'hc);
		@(posedge clk);
		{acc_valid, acc_matrix} <= {1'b1, 16'h0008};
		@(posedge clk);
		acc_valid <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("convicted_q", 4'h0, convicted_q);
		@(posedge clk);
		{acc_valid, acc_matrix} <= {1'b1, 16'h0088};
		@(posedge clk);
		acc_valid <= 1'b0;
		repeat (3) @(posedge clk);
		park <= 1'b0;
		#1 chk("convicted_q", 4'h8, convicted_q);
	endtask
	task automatic t_fault_init;
		@(posedge clk);
		bus_fail <= 1'b1;
		@(posedge clk);
		{bus_fail, want_clique, dly} <= {1'b0, 1'b0, 8'h01};
		#1 chk("link_tx_en_q", 1'b0, link_tx_en_q);
		chk("fail_q", 1'b1, fail_q);
		chk("major_mode_q", 3'h0, major_mode_q);
		wait_mode(3'h1, 4'h1);
		chk("convicted_q", 4'h0, convicted_q);
		wait_mode(3'h3, 4'h5);
		wait_mode(3'h3, 4'h6);
		wait_mode(3'h3, 4'h7);
		wait_mode(3'h4, 4'h8);
		@(posedge clk);
		self_check_err <= 1'b1;
		@(posedge clk);
		self_check_err <= 1'b0;
		#1 chk("link_tx_en_q", 1'b0, link_tx_en_q);
		chk("fail_q", 1'b1, fail_q);
		chk("major_mode_q", 3'h0, major_mode_q);
	endtask
	// stimulus: reset, then each scenario in turn
	initial
	begin
		{rst, ce, pwr_on_en, self_test_pass, self_test_fail, self_check_err, bus_fail} = 7'h60;
		{rx_valid, rx_in_window, rx_format_ok, client_valid, client_format_ok, acc_valid} = 6'h1a;
		{rx_lanes, eligible, acc_matrix, dly, want_clique, park} = {32'h0, 4'hf, 16'h0, 8'h06, 1'b1, 1'b0};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk) #1;
		t_self_test();
		t_join_pres();
		t_vote();
		t_convict();
		t_fault_init();
		tally_and_finish();
	end
endmodule // tb
